// File: hw/pioreg_pkg.sv
// peripheral i/o register bank constants, field positions and carriers
// assumes a 4-bit data memory bus from the cpu core on clk_sys
package pioreg_pkg;
   // ************************************************
   // memory map decode
   // ************************************************
   localparam logic [15:0] RAM_LAST = 16'h07FF;
   localparam logic [15:0] STACK_FIRST = 16'h0100;
   localparam logic [15:0] STACK_LAST = 16'h01FF;
   localparam logic [15:0] DISP_FIRST = 16'hF000;
   localparam int DISP_WORDS = 32;
   localparam int RAM_WORDS = 2048;
   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [15:0] OFS_CLOCK_SELECT_CTRL = 16'hFF00;
   localparam logic [15:0] OFS_POWER_COMPAT_CTRL = 16'hFF01;
   localparam logic [15:0] OFS_SUPPLY_DETECT_LEVEL = 16'hFF04;
   localparam logic [15:0] OFS_SUPPLY_DETECT_CTRL = 16'hFF05;
   localparam logic [15:0] OFS_FREQ_OUTPUT_CTRL = 16'hFF06;
   localparam logic [15:0] OFS_WATCHDOG_CTRL = 16'hFF07;
   localparam logic [15:0] OFS_KEY_GRP0_IRQ_SELECT = 16'hFF20;
   localparam logic [15:0] OFS_KEY_GRP0_INPUT = 16'hFF21;
   localparam logic [15:0] OFS_KEY_GRP0_COMPARE = 16'hFF22;
   localparam logic [15:0] OFS_KEY_GRP1_IRQ_SELECT = 16'hFF24;
   localparam logic [15:0] OFS_KEY_GRP1_INPUT = 16'hFF25;
   localparam logic [15:0] OFS_KEY_GRP1_COMPARE = 16'hFF26;
   localparam logic [15:0] OFS_KEY_SINGLE_IRQ_SELECT = 16'hFF28;
   localparam logic [15:0] OFS_KEY_SINGLE_INPUT = 16'hFF29;
   localparam logic [15:0] OFS_KEY_SINGLE_COMPARE = 16'hFF2A;
   localparam logic [15:0] OFS_KEY_SENSE_CTRL = 16'hFF2B;
   localparam logic [15:0] OFS_OUT_PORT0_FLOAT = 16'hFF30;
   localparam logic [15:0] OFS_OUT_PORT0_DATA = 16'hFF31;
   localparam logic [15:0] OFS_OUT_PORT1_FLOAT = 16'hFF32;
   localparam logic [15:0] OFS_OUT_PORT1_DATA = 16'hFF33;
   localparam logic [15:0] OFS_OUT_PORT2_FLOAT = 16'hFF34;
   // ************************************************
   // field positions
   // ************************************************
   localparam int BIT_CPU_CLOCK_SOURCE_SEL = 3;
   localparam int BIT_FAST_OSC_ON = 2;
   localparam int BIT_OP_VOLTAGE_SWITCH = 0;
   localparam int BIT_ADC_SUPPLY_SEL = 3;
   localparam int BIT_REGULATOR_SUPPLY_SEL = 2;
   localparam int BIT_DOUBLER_ON = 0;
   localparam int BIT_LOW_SUPPLY_RESULT = 1;
   localparam int BIT_SUPPLY_DETECT_ON = 0;
   localparam int BIT_FREQ_OUT_ENABLE = 3;
   localparam int BIT_WATCHDOG_ENABLE = 1;
   localparam int BIT_WATCHDOG_RESTART = 0;
   localparam int BIT_PORT0_BIT3 = 3;
   localparam int BIT_PORT0_BIT2 = 2;
   // ************************************************
   // reset values and masks of writable bits
   // ************************************************
   localparam logic [3:0] RST_ZERO = 4'h0;
   localparam logic [3:0] RST_ONES = 4'hF;
   localparam logic [3:0] RST_WATCHDOG = 4'h2;
   localparam logic [3:0] RST_SINGLE = 4'h1;
   localparam logic [3:0] MASK_CLOCK_SELECT = 4'hD;
   localparam logic [3:0] MASK_POWER_COMPAT = 4'hD;
   localparam logic [3:0] MASK_FREQ_OUT = 4'hB;
   localparam logic [3:0] MASK_BIT0 = 4'h1;
   // ************************************************
   // timing: frequency output dividers on the slow and fast oscillator ticks
   // ************************************************
   localparam int FREQ_OUTPUT_PIN_DIV_SLOW64 = 64;
   localparam int FREQ_OUTPUT_PIN_DIV_SLOW8 = 8;
   localparam int FREQ_OUTPUT_PIN_DIV_FAST = 2;
   // ************************************************
   // carriers
   // ************************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [3:0] wdata;
   } pioreg_req_s;
   typedef struct packed {
      logic [3:0] p0_out;
      logic [3:0] p0_oe_n;
      logic [3:0] p1_out;
      logic [3:0] p1_oe_n;
   } pioreg_pins_s;
   typedef enum logic [1:0] {
      PIOREG_FREQ_OUTPUT_PIN_S64 = 2'h0,
      PIOREG_FREQ_OUTPUT_PIN_S8 = 2'h1,
      PIOREG_FREQ_OUTPUT_PIN_F1 = 2'h3,
      PIOREG_FREQ_OUTPUT_PIN_F2 = 2'h2
   } pioreg_fsel_e;
endpackage

// File: hw/pioreg_bank.sv
// peripheral i/o register bank, ram and display memory of a 4-bit mcu
// assumes the cpu core issues one rd or wr per cycle on clk_sys, data 4 bits
`timescale 1ns/1ps
module pioreg_bank
   import pioreg_pkg::*;
#(
   parameter int RAM_DEPTH = RAM_WORDS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire pioreg_pkg::pioreg_req_s req,
   input wire logic stack16,
   input wire logic [15:0] stack_wdata,
   input wire logic [3:0] key_grp0_pins,
   input wire logic [3:0] key_grp1_pins,
   input wire logic single_key_pin,
   input wire logic low_supply_in,
   input wire logic slow_osc_tick,
   input wire logic fast_osc_tick,
   input wire logic timer_pulse_out_on,
   input wire logic timer_pulse_pin,
   output logic [3:0] rdata,
   output logic [15:0] stack_rdata,
   output logic access_error,
   output logic cpu_clock_source_sel,
   output logic fast_oscillator_on,
   output logic [3:0] detect_threshold_field,
   output logic supply_detect_on,
   output logic watchdog_enable_bit,
   output logic watchdog_restart_bit,
   output logic [8:0] key_irq_enable,
   output logic [8:0] key_compare,
   output logic key_sense_on,
   output logic freq_output_pin,
   output pioreg_pkg::pioreg_pins_s pins,
   output logic [3:0] port2_out,
   output logic [3:0] port2_oe_n
);
   import pioreg_pkg::*;

   // ************************************************
   // address decode
   // ************************************************
   function automatic logic in_ram(input logic [15:0] a);
      in_ram = (a <= RAM_LAST);
   endfunction
   function automatic logic in_stack(input logic [15:0] a);
      in_stack = (a >= STACK_FIRST) && (a <= STACK_LAST);
   endfunction
   function automatic logic in_disp(input logic [15:0] a);
      in_disp = (a >= DISP_FIRST) && (a < DISP_FIRST + 16'(DISP_WORDS));
   endfunction

   logic [3:0] ram_mem [RAM_DEPTH];
   logic [3:0] disp_mem [DISP_WORDS];
   logic [3:0] clk_ctrl_r, pwr_ctrl_r, svd_lvl_r, svd_ctrl_r, freq_output_pin_ctrl_r, wdt_ctrl_r;
   logic [3:0] k0_sel_r, k0_cmp_r, k1_sel_r, k1_cmp_r;
   logic k2_sel_r, k2_cmp_r, ksen_r;
   logic [3:0] p0_hiz_r, p0_dat_r, p1_dat_r;
   logic p1_hiz_r, p2_hiz_r;
   logic [3:0] io_rd;
   logic io_hit;
   logic wr_io;
   logic [6:0] freq_output_pin_cnt_r;
   logic [6:0] freq_output_pin_div;
   logic freq_output_pin_tick;
   logic freq_output_pin_level_r;

   assign wr_io = req.wr && !stack16;

   // ************************************************
   // ram and display memory
   // ************************************************
   // ram with nibble and stack word access
   always_ff @(posedge clk_sys) begin
      if (req.wr && in_ram(req.addr)) begin
         if (stack16 && in_stack(req.addr)) begin
            ram_mem[11'(req.addr)] <= stack_wdata[3:0];
            ram_mem[11'(req.addr + 16'h0001)] <= stack_wdata[7:4];
            ram_mem[11'(req.addr + 16'h0002)] <= stack_wdata[11:8];
            ram_mem[11'(req.addr + 16'h0003)] <= stack_wdata[15:12];
         end else if (!stack16) begin
            ram_mem[11'(req.addr)] <= req.wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_io && in_disp(req.addr)) begin
         disp_mem[5'(req.addr)] <= req.wdata;
      end
   end

   // ************************************************
   // system control registers
   // ************************************************
   // held values except the sampled low supply result and the restart strobe; power bits drive no logic here
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clk_ctrl_r <= RST_ZERO;
         pwr_ctrl_r <= RST_ZERO;
         svd_lvl_r <= RST_ZERO;
         svd_ctrl_r <= RST_ZERO;
         freq_output_pin_ctrl_r <= RST_ZERO;
         wdt_ctrl_r <= RST_WATCHDOG;
      end else begin
         if (wr_io && req.addr == OFS_CLOCK_SELECT_CTRL) begin
            clk_ctrl_r <= req.wdata & MASK_CLOCK_SELECT;
         end
         if (wr_io && req.addr == OFS_POWER_COMPAT_CTRL) begin
            pwr_ctrl_r <= req.wdata & MASK_POWER_COMPAT;
         end
         if (wr_io && req.addr == OFS_SUPPLY_DETECT_LEVEL) begin
            svd_lvl_r <= req.wdata;
         end
         if (wr_io && req.addr == OFS_SUPPLY_DETECT_CTRL) begin
            svd_ctrl_r[BIT_SUPPLY_DETECT_ON] <= req.wdata[BIT_SUPPLY_DETECT_ON];
         end
         // result sampled only while detection is on
         if (svd_ctrl_r[BIT_SUPPLY_DETECT_ON]) begin
            svd_ctrl_r[BIT_LOW_SUPPLY_RESULT] <= low_supply_in;
         end
         if (wr_io && req.addr == OFS_FREQ_OUTPUT_CTRL) begin
            freq_output_pin_ctrl_r <= req.wdata & MASK_FREQ_OUT;
         end
         // restart bit is a one-cycle strobe, never stored
         wdt_ctrl_r[BIT_WATCHDOG_RESTART] <= wr_io && req.addr == OFS_WATCHDOG_CTRL
            && req.wdata[BIT_WATCHDOG_RESTART];
         if (wr_io && req.addr == OFS_WATCHDOG_CTRL) begin
            wdt_ctrl_r[BIT_WATCHDOG_ENABLE] <= req.wdata[BIT_WATCHDOG_ENABLE];
         end
      end
   end

   // ************************************************
   // key input registers
   // ************************************************
   // selection, compare and sense bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         k0_sel_r <= RST_ZERO;
         k1_sel_r <= RST_ZERO;
         k0_cmp_r <= RST_ONES;
         k1_cmp_r <= RST_ONES;
         k2_sel_r <= 1'b0;
         k2_cmp_r <= 1'b1;
         ksen_r <= 1'b1;
      end else if (wr_io) begin
         case (req.addr)
            OFS_KEY_GRP0_IRQ_SELECT: k0_sel_r <= req.wdata;
            OFS_KEY_GRP0_COMPARE: k0_cmp_r <= req.wdata;
            OFS_KEY_GRP1_IRQ_SELECT: k1_sel_r <= req.wdata;
            OFS_KEY_GRP1_COMPARE: k1_cmp_r <= req.wdata;
            OFS_KEY_SINGLE_IRQ_SELECT: k2_sel_r <= req.wdata[0];
            OFS_KEY_SINGLE_COMPARE: k2_cmp_r <= req.wdata[0];
            OFS_KEY_SENSE_CTRL: ksen_r <= req.wdata[0];
            default: ;
         endcase
      end
   end

   // ************************************************
   // output port registers
   // ************************************************
   // data bits reset high so special outputs see a clean level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         p0_hiz_r <= RST_ZERO;
         p0_dat_r <= RST_ONES;
         p1_hiz_r <= 1'b0;
         p1_dat_r <= RST_ONES;
         p2_hiz_r <= 1'b0;
      end else if (wr_io) begin
         case (req.addr)
            OFS_OUT_PORT0_FLOAT: p0_hiz_r <= req.wdata;
            OFS_OUT_PORT0_DATA: p0_dat_r <= req.wdata;
            OFS_OUT_PORT1_FLOAT: p1_hiz_r <= req.wdata[0];
            OFS_OUT_PORT1_DATA: p1_dat_r <= req.wdata;
            OFS_OUT_PORT2_FLOAT: p2_hiz_r <= req.wdata[0];
            default: ;
         endcase
      end
   end

   // ************************************************
   // frequency output divider
   // ************************************************
   // fast codes divide the fast tick by two; the exact ratio is open
   always_comb begin
      case (pioreg_fsel_e'(freq_output_pin_ctrl_r[1:0]))
         PIOREG_FREQ_OUTPUT_PIN_S64: begin
            freq_output_pin_div = 7'(FREQ_OUTPUT_PIN_DIV_SLOW64 / 2);
            freq_output_pin_tick = slow_osc_tick;
         end
         PIOREG_FREQ_OUTPUT_PIN_S8: begin
            freq_output_pin_div = 7'(FREQ_OUTPUT_PIN_DIV_SLOW8 / 2);
            freq_output_pin_tick = slow_osc_tick;
         end
         default: begin
            freq_output_pin_div = 7'(FREQ_OUTPUT_PIN_DIV_FAST / 2);
            freq_output_pin_tick = fast_osc_tick;
         end
      endcase
   end

   // toggle every half period, held low while disabled
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         freq_output_pin_cnt_r <= 7'h00;
         freq_output_pin_level_r <= 1'b0;
      end else if (!freq_output_pin_ctrl_r[BIT_FREQ_OUT_ENABLE]) begin
         freq_output_pin_cnt_r <= 7'h00;
         freq_output_pin_level_r <= 1'b0;
      end else if (freq_output_pin_tick) begin
         if (freq_output_pin_cnt_r >= freq_output_pin_div - 7'h01) begin
            freq_output_pin_cnt_r <= 7'h00;
            freq_output_pin_level_r <= !freq_output_pin_level_r;
         end else begin
            freq_output_pin_cnt_r <= freq_output_pin_cnt_r + 7'h01;
         end
      end
   end

   // ************************************************
   // read mux
   // ************************************************
   // unused bits and unmapped addresses give zero
   always_comb begin
      io_hit = 1'b1;
      case (req.addr)
         OFS_CLOCK_SELECT_CTRL: io_rd = clk_ctrl_r;
         OFS_POWER_COMPAT_CTRL: io_rd = pwr_ctrl_r;
         OFS_SUPPLY_DETECT_LEVEL: io_rd = svd_lvl_r;
         OFS_SUPPLY_DETECT_CTRL: io_rd = svd_ctrl_r;
         OFS_FREQ_OUTPUT_CTRL: io_rd = freq_output_pin_ctrl_r;
         OFS_WATCHDOG_CTRL: io_rd = wdt_ctrl_r & 4'h2;
         OFS_KEY_GRP0_IRQ_SELECT: io_rd = k0_sel_r;
         OFS_KEY_GRP0_INPUT: io_rd = key_grp0_pins;
         OFS_KEY_GRP0_COMPARE: io_rd = k0_cmp_r;
         OFS_KEY_GRP1_IRQ_SELECT: io_rd = k1_sel_r;
         OFS_KEY_GRP1_INPUT: io_rd = key_grp1_pins;
         OFS_KEY_GRP1_COMPARE: io_rd = k1_cmp_r;
         OFS_KEY_SINGLE_IRQ_SELECT: io_rd = {3'h0, k2_sel_r};
         OFS_KEY_SINGLE_INPUT: io_rd = {3'h0, single_key_pin};
         OFS_KEY_SINGLE_COMPARE: io_rd = {3'h0, k2_cmp_r};
         OFS_KEY_SENSE_CTRL: io_rd = {3'h0, ksen_r};
         OFS_OUT_PORT0_FLOAT: io_rd = p0_hiz_r;
         OFS_OUT_PORT0_DATA: io_rd = p0_dat_r;
         OFS_OUT_PORT1_FLOAT: io_rd = {3'h0, p1_hiz_r};
         OFS_OUT_PORT1_DATA: io_rd = p1_dat_r;
         OFS_OUT_PORT2_FLOAT: io_rd = {3'h0, p2_hiz_r};
         default: begin
            io_rd = 4'h0;
            io_hit = 1'b0;
         end
      endcase
   end

   // registered read data, one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 4'h0;
         stack_rdata <= 16'h0000;
         access_error <= 1'b0;
      end else begin
         // stack word outside the window is refused
         access_error <= (req.rd || req.wr) && stack16 && !in_stack(req.addr);
         if (req.rd && stack16 && in_stack(req.addr)) begin
            stack_rdata <= {ram_mem[11'(req.addr + 16'h0003)], ram_mem[11'(req.addr + 16'h0002)],
               ram_mem[11'(req.addr + 16'h0001)], ram_mem[11'(req.addr)]};
         end
         if (req.rd && !stack16) begin
            if (in_ram(req.addr)) begin
               rdata <= ram_mem[11'(req.addr)];
            end else if (in_disp(req.addr)) begin
               rdata <= disp_mem[5'(req.addr)];
            end else begin
               rdata <= io_hit ? io_rd : 4'h0;
            end
         end
      end
   end

   // ************************************************
   // registered control and pin outputs
   // ************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clock_source_sel <= 1'b0;
         fast_oscillator_on <= 1'b0;
         detect_threshold_field <= 4'h0;
         supply_detect_on <= 1'b0;
         watchdog_enable_bit <= 1'b1;
         watchdog_restart_bit <= 1'b0;
         key_irq_enable <= 9'h000;
         key_compare <= 9'h1FF;
         key_sense_on <= 1'b1;
         freq_output_pin <= 1'b0;
         pins <= '{p0_out: 4'hF, p0_oe_n: 4'h0, p1_out: 4'hF, p1_oe_n: 4'h0};
         port2_out <= 4'hF;
         port2_oe_n <= 4'h0;
      end else begin
         cpu_clock_source_sel <= clk_ctrl_r[BIT_CPU_CLOCK_SOURCE_SEL];
         fast_oscillator_on <= clk_ctrl_r[BIT_FAST_OSC_ON];
         detect_threshold_field <= svd_lvl_r;
         supply_detect_on <= svd_ctrl_r[BIT_SUPPLY_DETECT_ON];
         watchdog_enable_bit <= wdt_ctrl_r[BIT_WATCHDOG_ENABLE];
         watchdog_restart_bit <= wdt_ctrl_r[BIT_WATCHDOG_RESTART];
         key_irq_enable <= ksen_r ? {k2_sel_r, k1_sel_r, k0_sel_r} : 9'h000;
         key_compare <= {k2_cmp_r, k1_cmp_r, k0_cmp_r};
         key_sense_on <= ksen_r;
         freq_output_pin <= freq_output_pin_level_r;
         // bit3 carries the frequency output when enabled
         pins.p0_out[BIT_PORT0_BIT3] <= freq_output_pin_ctrl_r[BIT_FREQ_OUT_ENABLE] ?
            freq_output_pin_level_r : p0_dat_r[BIT_PORT0_BIT3];
         // bit2 carries the timer pulse when on
         pins.p0_out[BIT_PORT0_BIT2] <= timer_pulse_out_on ?
            timer_pulse_pin : p0_dat_r[BIT_PORT0_BIT2];
         pins.p0_out[1:0] <= p0_dat_r[1:0];
         // float bit means output enable off
         pins.p0_oe_n <= p0_hiz_r;
         // port1 drives data, floats as a group
         pins.p1_out <= p1_dat_r;
         pins.p1_oe_n <= {4{p1_hiz_r}};
         port2_out <= 4'hF;
         port2_oe_n <= {4{p2_hiz_r}};
      end
   end

   // ************************************************
   // checks
   // ************************************************
   sequence s_restart_write;
      wr_io && req.addr == OFS_WATCHDOG_CTRL && req.wdata[BIT_WATCHDOG_RESTART];
   endsequence

   AST_WDT_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_restart_write |-> ##2 watchdog_restart_bit)
      else $error("restart write did not pulse");
   AST_WDT_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      req.rd && !stack16 && req.addr == OFS_WATCHDOG_CTRL |=> rdata[0] == 1'b0)
      else $error("restart bit read nonzero");
   AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      req.rd && !stack16 && req.addr == OFS_KEY_SENSE_CTRL |=> rdata[3:1] == 3'h0)
      else $error("unused bits read nonzero");
   AST_KEY_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      req.rd && !stack16 && req.addr == OFS_KEY_GRP0_INPUT |=> rdata == $past(key_grp0_pins))
      else $error("key data mismatch");
   AST_P1_FLOAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 pins.p1_oe_n == {4{$past(p1_hiz_r)}})
      else $error("port1 float mismatch");
   AST_P0_FREQ_OUTPUT_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      freq_output_pin_ctrl_r[BIT_FREQ_OUT_ENABLE] |=> pins.p0_out[3] == freq_output_pin)
      else $error("bit3 not frequency output");
   AST_P0_TIMER_PULSE_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timer_pulse_out_on |=> pins.p0_out[2] == $past(timer_pulse_pin))
      else $error("bit2 not timer pulse");
   AST_FREQ_OUTPUT_PIN_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !freq_output_pin_ctrl_r[BIT_FREQ_OUT_ENABLE] [*2] |=> !freq_output_pin)
      else $error("frequency output while disabled");
   AST_IRQ_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 (key_irq_enable[3:0] & ~$past(k0_sel_r)) == 4'h0)
      else $error("unselected key enabled");
   AST_STACK_WINDOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (req.wr || req.rd) && stack16 && !in_stack(req.addr) |=> access_error)
      else $error("stack outside window accepted");
endmodule

// File: tb/pioreg_cpu.sv
// cpu core stand-in issuing 4-bit data memory reads and writes
// assumes the bank takes req on rising clk_sys and answers rdata one cycle later
`timescale 1ns/1ps
module pioreg_cpu
   import pioreg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [3:0] rdata,
   output pioreg_pkg::pioreg_req_s req
);
   // ************************************************
   // bus cycles, changed on falling edges only
   // ************************************************
   logic freq_output_pin_on_r = 1'b0; // software shadow of the frequency output enable
   initial req = '0;
   // write: held across one rising edge, then released
   // port0 bit3 kept high while the frequency output enable is set
   task automatic wr(input logic [15:0] a, input logic [3:0] v);
      @(negedge clk_sys);
      if (a === OFS_FREQ_OUTPUT_CTRL) freq_output_pin_on_r = v[BIT_FREQ_OUT_ENABLE];
      if (a === OFS_OUT_PORT0_DATA && freq_output_pin_on_r) v = v | 4'h8;
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge clk_sys);
      @(negedge clk_sys);
      req = '0;
   endtask
   // read: nibble taken once the request edge has landed
   task automatic rd(input logic [15:0] a, output logic [3:0] v);
      @(negedge clk_sys);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
      @(posedge clk_sys);
      @(negedge clk_sys);
      req = '0;
      v = rdata;
   endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the peripheral i/o register bank
// assumes the cpu stand-in drives req; other inputs change on falling edges
`timescale 1ns/1ps
module testbench;
   import pioreg_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic stack16 = 1'b0;
   logic low_supply_in = 1'b0;
   logic single_key_pin = 1'b1;
   logic [3:0] key_grp0_pins = 4'hA;
   logic [3:0] key_grp1_pins = 4'h5;
   logic [15:0] stack_wdata = 16'hA5C3;
   logic timer_pulse_out_on = 1'b0;
   logic timer_pulse_pin = 1'b0;
   logic [3:0] rdata, port2_out, port2_oe_n, detect_threshold_field, d;
   logic [15:0] stack_rdata;
   logic [8:0] key_irq_enable, key_compare;
   logic access_error, clk_sel, osc_on, det_on, wd_en, wd_rst, sense_on, freq_output_pin;
   pioreg_pins_s pins;
   pioreg_req_s req;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int i, n;
   // address, reset value, written value, value read back
   logic [27:0] rows [22] = '{28'hFF000FD, 28'hFF010FD, 28'hFF040FF, 28'hFF05011, 28'hFF06033,
      28'hFF07222, 28'hFF200FF, 28'hFF21AFA, 28'hFF22F00, 28'hFF240FF, 28'hFF255F5,
      28'hFF26F55, 28'hFF280F1, 28'hFF291F1, 28'hFF2A1F1, 28'hFF2B1F1, 28'hFF30055,
      28'hFF31FAA, 28'hFF320F1, 28'hFF33F66, 28'hFF340F1, 28'hFF030F0};
   logic [15:0] mem_a [4] = '{16'h0000, 16'h07FF, 16'hF000, 16'hF01F};
   logic [15:0] per [4] = '{16'h40, 16'h8, 16'h2, 16'h2};
   pioreg_cpu i_pioreg_cpu (.clk_sys(clk_sys), .rdata(rdata), .req(req));
   pioreg_bank i_pioreg_bank (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .stack16(stack16),
      .stack_wdata(stack_wdata), .key_grp0_pins(key_grp0_pins), .key_grp1_pins(key_grp1_pins),
      .single_key_pin(single_key_pin), .low_supply_in(low_supply_in), .slow_osc_tick(1'b1),
      .fast_osc_tick(1'b1), .timer_pulse_out_on(timer_pulse_out_on),
      .timer_pulse_pin(timer_pulse_pin), .rdata(rdata),
      .stack_rdata(stack_rdata), .access_error(access_error), .cpu_clock_source_sel(clk_sel),
      .fast_oscillator_on(osc_on), .detect_threshold_field(detect_threshold_field),
      .supply_detect_on(det_on), .watchdog_enable_bit(wd_en), .watchdog_restart_bit(wd_rst),
      .key_irq_enable(key_irq_enable), .key_compare(key_compare), .key_sense_on(sense_on),
      .freq_output_pin(freq_output_pin), .pins(pins), .port2_out(port2_out),
      .port2_oe_n(port2_oe_n));
   // ************************************************
   // clock, timeout and reporting
   // ************************************************
   initial forever #2.5 clk_sys = ~clk_sys;
   // the whole run needs well under two thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // cycles between two rising edges of the frequency output
   task automatic fper(output int n);
      int f = -1;
      logic p = 1'b1;
      n = -1;
      for (int k = 0; k < 300; k++) begin
         @(negedge clk_sys);
         if (freq_output_pin === 1'b1 && p === 1'b0) begin
            if (f < 0) f = k;
            else if (n < 0) n = k - f;
         end
         p = freq_output_pin;
      end
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (6) @(negedge clk_sys);
      chk("reset outs", 16'h0DFF, {4'h0, wd_en, sense_on, freq_output_pin, key_compare});
      chk("reset pins", 16'hF0F0, pins);
      rst_n = 1'b1;
      for (i = 0; i < 22; i++) begin
         i_pioreg_cpu.rd(rows[i][27:12], d);
         chk($sformatf("reset %h", rows[i][27:12]), {12'h0, rows[i][11:8]}, {12'h0, d});
         i_pioreg_cpu.wr(rows[i][27:12], rows[i][7:4]);
         i_pioreg_cpu.rd(rows[i][27:12], d);
         chk($sformatf("back %h", rows[i][27:12]), {12'h0, rows[i][3:0]}, {12'h0, d});
      end
      chk("clock ctrl", 16'h0003, {14'h0, clk_sel, osc_on});
      chk("detect", 16'h001F, {11'h0, detect_threshold_field, det_on});
      chk("irq enable", 16'h01FF, {7'h0, key_irq_enable});
      chk("compare", 16'h0150, {7'h0, key_compare});
      chk("pins", 16'hA56F, pins);
      chk("port2 float", 16'h00FF, {8'h0, port2_out, port2_oe_n});
      $display("test register table done");
      low_supply_in = 1'b1;
      key_grp0_pins = 4'h3;
      i_pioreg_cpu.rd(OFS_SUPPLY_DETECT_CTRL, d);
      chk("low supply", 16'h0003, {12'h0, d});
      i_pioreg_cpu.rd(OFS_KEY_GRP0_INPUT, d);
      chk("key level", 16'h0003, {12'h0, d});
      i_pioreg_cpu.wr(OFS_KEY_SENSE_CTRL, 4'h0);
      @(negedge clk_sys);
      chk("sense off", 16'h0000, {6'h0, sense_on, key_irq_enable});
      i_pioreg_cpu.wr(OFS_WATCHDOG_CTRL, 4'h3);
      @(negedge clk_sys);
      chk("wd pulse", 16'h0003, {14'h0, wd_en, wd_rst});
      @(negedge clk_sys);
      chk("wd pulse end", 16'h0002, {14'h0, wd_en, wd_rst});
      $display("test keys and watchdog done");
      for (i = 0; i < 4; i++) begin
         i_pioreg_cpu.wr(mem_a[i], 4'(i + 6));
         i_pioreg_cpu.rd(mem_a[i], d);
         chk($sformatf("mem %h", mem_a[i]), 16'(i + 6), {12'h0, d});
      end
      i_pioreg_cpu.wr(16'h0800, 4'h9);
      i_pioreg_cpu.rd(16'h0800, d);
      chk("unbacked", 16'h0000, {12'h0, d});
      i_pioreg_cpu.wr(16'h0200, 4'h7);
      stack16 = 1'b1;
      i_pioreg_cpu.wr(16'h0100, 4'h0);
      i_pioreg_cpu.rd(16'h0100, d);
      chk("stack word", 16'hA5C3, stack_rdata);
      i_pioreg_cpu.wr(16'h0200, 4'h0);
      chk("stack error", 16'h0001, {15'h0, access_error});
      stack16 = 1'b0;
      i_pioreg_cpu.rd(16'h0200, d);
      chk("ram kept", 16'h0007, {12'h0, d});
      $display("test memory done");
      for (i = 0; i < 4; i++) begin
         i_pioreg_cpu.wr(OFS_FREQ_OUTPUT_CTRL, 4'h8 | 4'(i));
         fper(n);
         chk("freq period", per[i], 16'(n));
      end
      i_pioreg_cpu.wr(OFS_OUT_PORT0_DATA, 4'h0);
      i_pioreg_cpu.rd(OFS_OUT_PORT0_DATA, d);
      chk("port0 keep", 16'h0008, {12'h0, d});
      // data bit2 held high, so a low pin proves the timer pulse route
      i_pioreg_cpu.wr(OFS_OUT_PORT0_DATA, 4'h4);
      timer_pulse_out_on = 1'b1;
      @(negedge clk_sys);
      chk("timer pulse", 16'h0000, {15'h0, pins.p0_out[2]});
      timer_pulse_out_on = 1'b0;
      i_pioreg_cpu.wr(OFS_FREQ_OUTPUT_CTRL, 4'h0);
      repeat (3) @(negedge clk_sys);
      chk("freq off", 16'h0000, {15'h0, freq_output_pin});
      rst_n = 1'b0;
      #1;
      chk("rerun pins", 16'hF0F0, pins);
      @(negedge clk_sys);
      rst_n = 1'b1;
      i_pioreg_cpu.rd(OFS_WATCHDOG_CTRL, d);
      chk("rerun wd", 16'h0002, {12'h0, d});
      $display("test frequency and reset done");
      results();
   end
endmodule
